// ---- logic/irq_wdt_pkg.sv ----
// Purpose: shared constants and types for the interrupt, watchdog and halt block
// Assumes: single system clock domain, data memory address bus of 8 bits
// Notes: field positions follow the interrupt control register layout
package irq_wdt_pkg;
   localparam logic [7:0] INTERRUPT_CONTROL_ADDR = 8'h0b;
   localparam logic [7:0] INTERRUPT_CONTROL_RESET = 8'h00;
   // bit 7 is the test bit: never stored, reads as zero
   localparam logic [7:0] INTERRUPT_CONTROL_WRITE_MASK = 8'h7f;
   localparam int GIE_BIT = 0;
   localparam int EN_LO = 1;
   localparam int EN_HI = 3;
   localparam int FLAG_LO = 4;
   localparam int FLAG_HI = 6;
   localparam int EXT_FLAG_BIT = 4;
   localparam logic [7:0] EXT_VECTOR = 8'h04;
   localparam logic [7:0] TMR_VECTOR = 8'h08;
   localparam logic [7:0] CNV_VECTOR = 8'h0c;
   localparam int WDT_BITS = 16;
   localparam logic [WDT_BITS-1:0] WDT_LAST = 16'hffff;
   localparam logic [1:0] PRESC_LAST = 2'h3;
   localparam logic [10:0] WAKE_DELAY_CYCLES = 11'h400;
   localparam logic [10:0] WAKE_LAST = WAKE_DELAY_CYCLES - 11'h001;
   localparam logic [10:0] PIN_IDLE = 11'h7ff;

   typedef struct packed {
      logic osc_rc;
      logic wdt_en;
      logic wdt_src_rc;
      logic wdt_rc_en;
      logic clr_paired;
      logic [7:0] porta_wake;
   } opt_type;

   typedef struct packed {
      logic return_with_enable;
      logic plain_return;
      logic clear_watchdog_single;
      logic clear_watchdog_first;
      logic clear_watchdog_second;
      logic halt;
   } instr_type;

   typedef struct packed {
      logic take;
      logic [7:0] vector;
   } take_type;

   typedef struct packed {
      logic timeout_flag;
      logic power_down_flag;
   } status_type;

   typedef enum logic [2:0] {
      ST_RUN = 3'h1,
      ST_HALT = 3'h2,
      ST_WAKE = 3'h4
   } state_type;
endpackage : irq_wdt_pkg

// ---- logic/wdt_counter.sv ----
// Purpose: watchdog counter, one overflow pulse every 2^16 ticks
// Assumes: tick is a one-cycle enable in the system clock domain
// Notes: clear zeroes the whole counter; the instruction clock prescaler is not cleared
module wdt_counter (
   input wire logic clk,
   input wire logic resetn,
   input wire logic tick,
   input wire logic clear,
   output logic overflow
);
   import irq_wdt_pkg::*;

   logic [WDT_BITS-1:0] count;

   always_ff @(posedge clk) begin
      if (!resetn || clear) begin
         count <= '0;
      end else if (tick) begin
         count <= count + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         overflow <= 1'b0;
      end else begin
         overflow <= tick && !clear && (count == WDT_LAST);
      end
   end

   a_wdt_clear_zero: assert property (@(posedge clk) disable iff (!resetn)
      clear |=> (count == '0) && !overflow)
      else $error("watchdog not zeroed by clear");
endmodule : wdt_counter

// ---- logic/irq_watchdog_halt_control.sv ----
// Purpose: interrupt control register, priority vectoring, watchdog and halt control
// Assumes: core gives one-cycle instruction strobes and the sample_phase pulse
// Notes: pins and the watchdog rc clock are sampled through three flip-flops
module irq_watchdog_halt_control (
   input wire logic CLK_SYS,
   input wire logic RESETN,
   input wire irq_wdt_pkg::opt_type OPTIONS,
   input wire irq_wdt_pkg::instr_type INSTR,
   input wire logic STACK_FULL,
   input wire logic SAMPLE_PHASE,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WE,
   output logic [7:0] REG_RDATA,
   input wire logic EXT_IRQ_PIN_N,
   input wire logic TIMER_OVF,
   input wire logic CONVERTER_DONE,
   input wire logic [7:0] PORT_A,
   input wire logic EXTERNAL_RESET_PIN_N,
   input wire logic WDT_RC_CLK,
   output irq_wdt_pkg::take_type IRQ,
   output irq_wdt_pkg::status_type STATUS_FLAGS,
   output logic CHIP_RESET,
   output logic WARM_RESET,
   output logic HALTED,
   output logic CORE_RUN,
   output logic SYS_OSC_RUN,
   output logic OSC_OUT_PIN,
   output logic OSC_OUT_OE_N
);
   import irq_wdt_pkg::*;

   function automatic logic [2:0] first_of(input logic [2:0] v);
      if (v[0]) return 3'h1;
      if (v[1]) return 3'h2;
      if (v[2]) return 3'h4;
      return 3'h0;
   endfunction : first_of

   function automatic logic [7:0] vec_of(input logic [2:0] onehot);
      if (onehot[0]) return EXT_VECTOR;
      if (onehot[1]) return TMR_VECTOR;
      return CNV_VECTOR;
   endfunction : vec_of

   opt_type opt;
   state_type state;
   logic [10:0] wake_cnt;
   logic [7:0] interrupt_control;
   logic [7:0] next_interrupt_control;
   logic [1:0] presc;
   logic first_seen;
   logic second_seen;
   logic wdt_ovf;
   logic [10:0] pin_raw;
   logic [10:0] pin_s1;
   logic [10:0] pin_s2;
   logic [10:0] pin_s3;
   logic [10:0] pin_f;
   logic [10:0] pin_d;

   // options are straps: taken while reset is held, frozen afterwards
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         opt <= OPTIONS;
      end
   end

   // pins and the rc clock: a level moves only once stages two and three agree
   assign pin_raw = {WDT_RC_CLK, EXTERNAL_RESET_PIN_N, EXT_IRQ_PIN_N, PORT_A};

   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         pin_s1 <= PIN_IDLE;
         pin_s2 <= PIN_IDLE;
         pin_s3 <= PIN_IDLE;
         pin_f <= PIN_IDLE;
         pin_d <= PIN_IDLE;
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_f <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 | pin_s3));
         pin_d <= pin_f;
      end
   end

   logic rc_edge;
   logic rst_pin_low;
   logic ext_fall;
   logic [7:0] porta_fall;
   assign rc_edge = pin_f[10] && !pin_d[10];
   assign rst_pin_low = !pin_f[9];
   assign ext_fall = pin_d[8] && !pin_f[8];
   assign porta_fall = pin_d[7:0] & ~pin_f[7:0];

   logic run;
   logic halted;
   assign run = (state == ST_RUN);
   assign halted = (state == ST_HALT);

   // instruction clock: system clock divided by four, frozen with the oscillator
   logic instr_tick;
   assign instr_tick = (presc == PRESC_LAST) && !halted;

   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         presc <= 2'h0;
      end else if (!halted) begin
         presc <= presc + 2'h1;
      end
   end

   // crystal mode leaves the pin to the resonator
   assign OSC_OUT_PIN = presc[1];
   assign OSC_OUT_OE_N = !opt.osc_rc;
   assign SYS_OSC_RUN = !halted;

   // watchdog clocking; with the rc oscillator optioned off the rc path is dead
   logic wdt_tick;
   assign wdt_tick = opt.wdt_en && (opt.wdt_src_rc ? (rc_edge && opt.wdt_rc_en)
                                                  : instr_tick);

   logic core_reset_evt;
   logic halt_enter;
   logic clr_fire;
   logic wdt_clear;
   assign core_reset_evt = rst_pin_low || (wdt_ovf && !halted);
   assign halt_enter = INSTR.halt && run && !core_reset_evt;
   assign clr_fire = opt.wdt_en && run && (opt.clr_paired
      ? ((first_seen || INSTR.clear_watchdog_first)
         && (second_seen || INSTR.clear_watchdog_second))
      : INSTR.clear_watchdog_single);
   assign wdt_clear = clr_fire || rst_pin_low || halt_enter;

   // paired mode: either half may come first, the pair clears together
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN || wdt_clear) begin
         first_seen <= 1'b0;
         second_seen <= 1'b0;
      end else if (opt.wdt_en && opt.clr_paired && run) begin
         if (INSTR.clear_watchdog_first) first_seen <= 1'b1;
         if (INSTR.clear_watchdog_second) second_seen <= 1'b1;
      end
   end

   wdt_counter u_wdt (
      .clk(CLK_SYS),
      .resetn(RESETN),
      .tick(wdt_tick),
      .clear(wdt_clear),
      .overflow(wdt_ovf)
   );

   // interrupt requests and acknowledge
   logic [2:0] set_evt;
   logic [2:0] new_set;
   logic [2:0] pend;
   logic [2:0] take_mask;
   logic take_now;
   logic reg_hit;
   assign set_evt = {CONVERTER_DONE, TIMER_OVF, ext_fall};
   // a flag already up before halt gives no fresh edge, so cannot wake
   assign new_set = set_evt & ~interrupt_control[FLAG_HI:FLAG_LO];
   assign pend = interrupt_control[FLAG_HI:FLAG_LO] & interrupt_control[EN_HI:EN_LO];
   assign take_now = run && SAMPLE_PHASE && interrupt_control[GIE_BIT] && !STACK_FULL
                     && (pend != 3'h0) && !core_reset_evt;
   assign take_mask = take_now ? first_of(pend) : 3'h0;
   assign reg_hit = REG_WE && (REG_ADDR == INTERRUPT_CONTROL_ADDR);

   always_comb begin
      next_interrupt_control = interrupt_control;
      if (reg_hit) begin
         next_interrupt_control = REG_WDATA & INTERRUPT_CONTROL_WRITE_MASK;
      end
      if (INSTR.return_with_enable && run) begin
         next_interrupt_control[GIE_BIT] = 1'b1;
      end
      if (take_now) begin
         next_interrupt_control[GIE_BIT] = 1'b0;
      end
      // a fresh request beats a clear in the same cycle
      next_interrupt_control[FLAG_HI:FLAG_LO] = (next_interrupt_control[FLAG_HI:FLAG_LO] & ~take_mask)
                                   | set_evt;
   end

   // warm reset during halt leaves the register as it was
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN || core_reset_evt) begin
         interrupt_control <= INTERRUPT_CONTROL_RESET;
      end else begin
         interrupt_control <= next_interrupt_control;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         IRQ <= '0;
      end else begin
         IRQ.take <= take_now;
         if (take_now) begin
            IRQ.vector <= vec_of(take_mask);
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         REG_RDATA <= 8'h00;
      end else begin
         REG_RDATA <= (REG_ADDR == INTERRUPT_CONTROL_ADDR) ? interrupt_control : 8'h00;
      end
   end

   // timeout and power-down flags
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         STATUS_FLAGS <= '0;
      end else begin
         if (halt_enter) begin
            STATUS_FLAGS.power_down_flag <= 1'b1;
            STATUS_FLAGS.timeout_flag <= 1'b0;
         end else if (clr_fire) begin
            STATUS_FLAGS <= '0;
         end else if (rst_pin_low && halted) begin
            STATUS_FLAGS.timeout_flag <= 1'b0;
         end
         if (wdt_ovf) begin
            STATUS_FLAGS.timeout_flag <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         CHIP_RESET <= 1'b0;
         WARM_RESET <= 1'b0;
      end else begin
         CHIP_RESET <= core_reset_evt;
         WARM_RESET <= wdt_ovf && halted;
      end
   end

   // halt, wake and the dummy delay; continuing or vectoring is decided later
   // by the normal sampling path, so a wake with a masked source just resumes
   logic wake_evt;
   assign wake_evt = rst_pin_low || wdt_ovf || ((porta_fall & opt.porta_wake) != 8'h00)
                     || (new_set != 3'h0);

   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         state <= ST_RUN;
         wake_cnt <= 11'h000;
      end else begin
         case (state)
            ST_RUN: begin
               if (core_reset_evt) begin
                  state <= ST_WAKE;
                  wake_cnt <= 11'h000;
               end else if (halt_enter) begin
                  state <= ST_HALT;
               end
            end
            ST_HALT: begin
               if (wake_evt) begin
                  state <= ST_WAKE;
                  wake_cnt <= 11'h000;
               end
            end
            ST_WAKE: begin
               if (core_reset_evt) begin
                  wake_cnt <= 11'h000;
               end else if (wake_cnt == WAKE_LAST) begin
                  state <= ST_RUN;
               end else begin
                  wake_cnt <= wake_cnt + 11'h001;
               end
            end
            default: begin
               state <= ST_RUN;
            end
         endcase
      end
   end

   assign HALTED = halted;
   assign CORE_RUN = run;

   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESETN);

   a_return_with_enable_sets_gie: assert property (INSTR.return_with_enable && run && !take_now
      && !core_reset_evt |=> interrupt_control[GIE_BIT])
      else $error("return with enable did not set global enable");
   a_ret_keeps_gie: assert property (INSTR.plain_return && !INSTR.return_with_enable
      && !reg_hit && !take_now && !core_reset_evt |=> interrupt_control[GIE_BIT] == $past(interrupt_control[GIE_BIT]))
      else $error("plain return changed global enable");
   a_take_clears: assert property (take_now |=> IRQ.take && !interrupt_control[GIE_BIT]
      && (!$past(take_mask[0]) || !interrupt_control[EXT_FLAG_BIT]
      || $past(set_evt[0])))
      else $error("accept did not clear enable or flag");
   a_ext_priority: assert property (take_now && pend[0] |=> IRQ.vector == EXT_VECTOR)
      else $error("external request lost priority");
   a_tmr_priority: assert property (take_now && (pend[1:0] == 2'h2)
      |=> IRQ.vector == TMR_VECTOR)
      else $error("timer vector wrong");
   a_gie_blocks: assert property (!interrupt_control[GIE_BIT] |=> !IRQ.take)
      else $error("acknowledge with global enable low");
   a_stack_blocks: assert property (STACK_FULL |=> !IRQ.take)
      else $error("acknowledge with stack full");
   a_ext_fall_flag: assert property (ext_fall && !core_reset_evt
      |=> interrupt_control[EXT_FLAG_BIT])
      else $error("external falling edge did not set flag");
   a_halt_flags: assert property (halt_enter |=> halted
      && STATUS_FLAGS.power_down_flag && !SYS_OSC_RUN)
      else $error("halt entry flags wrong");
   a_wdt_ovf_reset: assert property (wdt_ovf && !halted |=> CHIP_RESET
      && STATUS_FLAGS.timeout_flag && !WARM_RESET)
      else $error("running overflow did not cause chip reset");
   a_wake_delay: assert property (run && !$past(run)
      |-> $past(wake_cnt) == WAKE_LAST)
      else $error("resumed before the dummy delay ended");
   a_old_flag_nowake: assert property (halted && !wake_evt |=> halted)
      else $error("left halt without a wake event");

   c_irq_taken: cover property (take_now ##1 IRQ.take);
   c_halt_wake: cover property (halted ##1 (state == ST_WAKE));
   c_warm_reset: cover property (WARM_RESET);
   c_paired_clear: cover property (clr_fire && opt.clr_paired);
endmodule : irq_watchdog_halt_control

// ---- verification/core_model.sv ----
// Purpose: processor core model issuing instruction strobes, phase pulses and stack room
// Assumes: the bench hands one-cycle instruction requests on req
// Notes: stack depth is a plain default of our own; force_full lets a test fill the stack
module core_model #(
   parameter int STACK_DEPTH = 4
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic take,
   input wire irq_wdt_pkg::instr_type req,
   input wire logic force_full,
   output irq_wdt_pkg::instr_type instr,
   output logic sample_phase,
   output logic stack_full
);
   timeunit 1ns;
   timeprecision 100ps;
   import irq_wdt_pkg::*;
   int depth;
   logic [1:0] phase;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         phase <= 2'h0;
         instr <= '0;
      end else begin
         phase <= phase + 2'h1;
         instr <= req;
      end
   end
   // one pulse per instruction cycle, the system clock divided by four
   assign sample_phase = (phase == 2'h3);
   always_ff @(posedge clk) begin
      if (!resetn)
         depth <= 0;
      else if (take)
         depth <= depth + 1;
      else if (instr.return_with_enable || instr.plain_return)
         depth <= depth - 1;
   end
   assign stack_full = force_full || (depth >= STACK_DEPTH);
endmodule : core_model

// ---- verification/irq_watchdog_halt_control_tb.sv ----
// Purpose: self-checking bench for interrupt control, halt and wake handling
// Assumes: watchdog overflow is out of reach in a short run, so it is not exercised
// Notes: inputs change 1 ns after the rising edge
module irq_watchdog_halt_control_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import irq_wdt_pkg::*;
   logic clk_sys, resetn, ext_n, tmr, cnv, rc_clk, we, force_full, v;
   logic rst_pin_n;
   int wait_n;
   logic [7:0] addr, wdata, rdata, port_a;
   opt_type opts;
   instr_type req, instr;
   take_type irq;
   status_type st;
   logic sample, sfull, chip_rst, warm_rst, halted, core_run, osc_run, osc_pin, osc_oe_n;
   int n_mismatch = 0;
   int n_tests = 0;
   int cycles = 0;

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      rc_clk = 1'b0;
      forever #40 rc_clk = ~rc_clk;
   end

   irq_watchdog_halt_control dut (.CLK_SYS(clk_sys), .RESETN(resetn), .OPTIONS(opts),
      .INSTR(instr), .STACK_FULL(sfull), .SAMPLE_PHASE(sample), .REG_ADDR(addr),
      .REG_WDATA(wdata), .REG_WE(we), .REG_RDATA(rdata), .EXT_IRQ_PIN_N(ext_n),
      .TIMER_OVF(tmr), .CONVERTER_DONE(cnv), .PORT_A(port_a),
      .EXTERNAL_RESET_PIN_N(rst_pin_n), .WDT_RC_CLK(rc_clk), .IRQ(irq), .STATUS_FLAGS(st),
      .CHIP_RESET(chip_rst), .WARM_RESET(warm_rst), .HALTED(halted), .CORE_RUN(core_run),
      .SYS_OSC_RUN(osc_run), .OSC_OUT_PIN(osc_pin), .OSC_OUT_OE_N(osc_oe_n));

   core_model core (.clk(clk_sys), .resetn(resetn), .take(irq.take), .req(req),
      .force_full(force_full), .instr(instr), .sample_phase(sample), .stack_full(sfull));

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : step

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      we = 1'b1;
      step(1);
      we = 1'b0;
   endtask : wr

   task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
      addr = a;
      step(1);
      check(rdata, exp);
   endtask : rd_check

   task automatic issue(input logic [5:0] code);
      req = instr_type'(code);
      step(1);
      req = '0;
   endtask : issue

   // scans a bounded window, so a missing acknowledge cannot hang the run
   task automatic wait_take(input logic want, input logic [7:0] vec);
      int k;
      k = 0;
      while (irq.take !== 1'b1 && k < 16) begin
         step(1);
         k++;
      end
      check({7'h0, irq.take}, {7'h0, want});
      if (want)
         check(irq.vector, vec);
   endtask : wait_take

   task automatic halt_wake();
      int k;
      issue(6'h01);
      step(20);
      check({4'h0, halted, osc_run, st}, 8'h09);
      port_a = 8'hfe;
      k = 0;
      while (halted === 1'b1 && k < 20) begin
         step(1);
         k++;
      end
      k = 0;
      while (core_run !== 1'b1 && k < 2000) begin
         step(1);
         k++;
      end
      check(8'(k == 1024), 8'h01);
      port_a = 8'hff;
   endtask : halt_wake

   task automatic do_reset(input logic [12:0] o);
      opts = opt_type'(o);
      resetn = 1'b0;
      step(3);
      resetn = 1'b1;
   endtask : do_reset

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         close_out();
      end
   end

   initial begin
      {ext_n, tmr, cnv, we, force_full} = 5'b10000;
      rst_pin_n = 1'b1;
      addr = 8'h00;
      wdata = 8'h00;
      port_a = 8'hff;
      req = '0;
      do_reset(13'h1a01);
      rd_check(INTERRUPT_CONTROL_ADDR, INTERRUPT_CONTROL_RESET);
      check({6'h0, st}, 8'h00);
      check({7'h0, osc_oe_n}, 8'h00);
      for (int i = 0; i < 4; i++) begin
         v = osc_pin;
         step(2);
         check({7'h0, osc_pin}, {7'h0, ~v});
      end
      wr(INTERRUPT_CONTROL_ADDR, 8'h0e);
      rd_check(INTERRUPT_CONTROL_ADDR, 8'h0e);
      rd_check(8'h0a, 8'h00);
      ext_n = 1'b0;
      tmr = 1'b1;
      cnv = 1'b1;
      step(1);
      {tmr, cnv} = 2'b00;
      step(6);
      ext_n = 1'b1;
      rd_check(INTERRUPT_CONTROL_ADDR, 8'h7e);
      wait_take(1'b0, 8'h00);
      wr(INTERRUPT_CONTROL_ADDR, 8'h7f);
      wait_take(1'b1, EXT_VECTOR);
      rd_check(INTERRUPT_CONTROL_ADDR, 8'h6e);
      issue(6'h20);
      wait_take(1'b1, TMR_VECTOR);
      issue(6'h10);
      wait_take(1'b0, 8'h00);
      rd_check(INTERRUPT_CONTROL_ADDR, 8'h4e);
      force_full = 1'b1;
      wr(INTERRUPT_CONTROL_ADDR, 8'h4f);
      wait_take(1'b0, 8'h00);
      force_full = 1'b0;
      wait_take(1'b1, CNV_VECTOR);
      tmr = 1'b1;
      step(1);
      tmr = 1'b0;
      step(2);
      halt_wake();
      issue(6'h08);
      step(2);
      check({6'h0, st}, 8'h00);
      do_reset(13'h0201);
      step(1);
      check({7'h0, osc_oe_n}, 8'h01);
      halt_wake();
      issue(6'h08);
      step(2);
      check({6'h0, st}, 8'h01);
      do_reset(13'h0b01);
      halt_wake();
      issue(6'h08);
      step(2);
      check({6'h0, st}, 8'h01);
      issue(6'h04);
      step(1);
      issue(6'h02);
      step(2);
      check({6'h0, st}, 8'h00);
      // reset pin during halt: chip reset and wake, power-down survives
      wr(INTERRUPT_CONTROL_ADDR, 8'h0e);
      issue(6'h01);
      step(3);
      rst_pin_n = 1'b0;
      step(6);
      check({2'h0, warm_rst, halted, chip_rst, core_run, st}, 8'h09);
      rd_check(INTERRUPT_CONTROL_ADDR, 8'h00);
      rst_pin_n = 1'b1;
      wait_n = 0;
      while (core_run !== 1'b1 && wait_n < 2000) begin
         step(1);
         wait_n++;
      end
      // four edges of pin filtering, then the full dummy delay
      check(8'(wait_n == 1028), 8'h01);
      check({5'h0, chip_rst, st}, 8'h01);
      close_out();
   end
endmodule : irq_watchdog_halt_control_tb
